// file: fpec_flash_ctrl.sv
// Flash program and erase sequencer with lock, keys and protection
`timescale 1ns/1ps
module fpec_flash_ctrl #(
  parameter int PAGE_ERASE_CYCLES = fpec_pkg::PAGE_ERASE_CYC,
  parameter int MASS_ERASE_CYCLES = fpec_pkg::MASS_ERASE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cmd_wr_i,
  input wire logic ps_wr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic dbg_i,
  input wire logic write_protect_option_i,
  input wire logic program_width_select_i,
  input wire logic mem_wr_i,
  input wire logic [15:0] mem_addr_i,
  input wire logic [7:0] mem_wdata_i,
  input wire logic [15:0] flash_word_i,
  output logic [2:0] controller_state_field_o,
  output logic [7:0] page_select_rdata_o,
  output logic core_stall_o,
  output logic fl_prog_o,
  output logic fl_page_erase_o,
  output logic fl_mass_erase_o,
  output logic fl_info_o,
  output logic [15:0] fl_addr_o,
  output logic [15:0] fl_data_o,
  output logic [1:0] fl_byte_en_o,
  output logic refused_o
);
  typedef struct packed {
    fpec_pkg::fpec_state_t st;
    logic [7:0] page;
    logic [7:0] ps_rd;
    logic hold_vld;
    logic [7:0] hold_byte;
    logic [2:0] status;
    logic stall;
    logic prog;
    logic perase;
    logic merase;
    logic info;
    logic [15:0] addr;
    logic [15:0] data;
    logic [1:0] ben;
    logic refused;
  } fpec_ctrl_t;

  fpec_ctrl_t cur_reg;
  fpec_ctrl_t cur_next;
  logic [7:0] bp_val;
  logic bp_wr;
  logic op_done;
  logic tmr_load;
  logic [fpec_pkg::TIMER_W-1:0] tmr_cycles;
  logic page_prot;
  logic page_hit;
  logic user_ok;

  // Protection decode against the active page
  assign page_prot = fpec_pkg::page_protected(cur_reg.page, bp_val);
  assign page_hit = mem_addr_i[15:fpec_pkg::ADDR_PAGE_LSB] ==
                    cur_reg.page[fpec_pkg::PAGE_W-1:0];
  assign user_ok = write_protect_option_i && !page_prot;

  // Page select address goes to block protect while redirected
  assign bp_wr = ps_wr_i && (cur_reg.st == fpec_pkg::FPEC_BP_SEL);

  fpec_block_prot u_bprot (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_i(bp_wr),
    .data_i(wr_data_i),
    .bp_o(bp_val)
  );

  // Timer is loaded on entry to any busy state
  always_comb begin
    tmr_load = 1'b0;
    tmr_cycles = '0;
    if (cur_reg.st != fpec_pkg::FPEC_PROG &&
        cur_next.st == fpec_pkg::FPEC_PROG) begin
      tmr_load = 1'b1;
      tmr_cycles = fpec_pkg::TIMER_W'(fpec_pkg::PROG_CYC);
    end else if (cur_reg.st != fpec_pkg::FPEC_PERASE &&
                 cur_next.st == fpec_pkg::FPEC_PERASE) begin
      tmr_load = 1'b1;
      tmr_cycles = fpec_pkg::TIMER_W'(PAGE_ERASE_CYCLES);
    end else if (cur_reg.st != fpec_pkg::FPEC_MERASE &&
                 cur_next.st == fpec_pkg::FPEC_MERASE) begin
      tmr_load = 1'b1;
      tmr_cycles = fpec_pkg::TIMER_W'(MASS_ERASE_CYCLES);
    end
  end

  fpec_op_timer #(
    .W(fpec_pkg::TIMER_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .load_i(tmr_load),
    .cycles_i(tmr_cycles),
    .done_o(op_done)
  );

  // Sequencer: keys, page check, programming and erase
  always_comb begin
    cur_next = cur_reg;
    cur_next.prog = 1'b0;
    cur_next.perase = 1'b0;
    cur_next.merase = 1'b0;
    cur_next.refused = 1'b0;
    unique case (cur_reg.st)
      fpec_pkg::FPEC_LOCKED: begin
        if (cmd_wr_i) begin
          if (wr_data_i == fpec_pkg::CMD_KEY1) begin
            cur_next.st = fpec_pkg::FPEC_KEY1;
          end else if (wr_data_i == fpec_pkg::CMD_BP_SELECT) begin
            cur_next.st = fpec_pkg::FPEC_BP_SEL;
          end
        end else if (ps_wr_i) begin
          cur_next.page = wr_data_i;
        end
      end
      fpec_pkg::FPEC_KEY1: begin
        if (cmd_wr_i && wr_data_i == fpec_pkg::CMD_KEY2) begin
          cur_next.st = fpec_pkg::FPEC_KEY2;
        end else if (cmd_wr_i || ps_wr_i) begin
          cur_next.st = fpec_pkg::FPEC_LOCKED;
        end
      end
      fpec_pkg::FPEC_KEY2: begin
        if (ps_wr_i) begin
          // Second page write must repeat the first
          if (wr_data_i == cur_reg.page) begin
            cur_next.st = fpec_pkg::FPEC_UNLOCKED;
            cur_next.hold_vld = 1'b0;
          end else begin
            cur_next.st = fpec_pkg::FPEC_LOCKED;
            cur_next.page = wr_data_i;
          end
        end else if (cmd_wr_i) begin
          cur_next.st = fpec_pkg::FPEC_LOCKED;
        end
      end
      fpec_pkg::FPEC_UNLOCKED: begin
        if (cmd_wr_i) begin
          if (wr_data_i == fpec_pkg::CMD_PAGE_ERASE && user_ok) begin
            cur_next.st = fpec_pkg::FPEC_PERASE;
            cur_next.perase = 1'b1;
            cur_next.info = cur_reg.page[fpec_pkg::INFO_BIT];
            cur_next.addr = {cur_reg.page[fpec_pkg::PAGE_W-1:0],
                             9'h000};
          end else if (wr_data_i == fpec_pkg::CMD_MASS_ERASE && dbg_i) begin
            cur_next.st = fpec_pkg::FPEC_MERASE;
            cur_next.merase = 1'b1;
            cur_next.info = 1'b0;
            cur_next.addr = 16'h0000;
          end else begin
            // Refused erase or any other value closes the page
            cur_next.st = fpec_pkg::FPEC_LOCKED;
            cur_next.refused = (wr_data_i == fpec_pkg::CMD_PAGE_ERASE) ||
                               (wr_data_i == fpec_pkg::CMD_MASS_ERASE);
          end
        end else if (mem_wr_i) begin
          if (!user_ok || !page_hit) begin
            cur_next.refused = 1'b1;
          end else if (program_width_select_i && !mem_addr_i[0]) begin
            // Even byte waits for its odd partner
            cur_next.hold_vld = 1'b1;
            cur_next.hold_byte = mem_wdata_i;
          end else begin
            cur_next.st = fpec_pkg::FPEC_PROG;
            cur_next.prog = 1'b1;
            cur_next.info = cur_reg.page[fpec_pkg::INFO_BIT];
            cur_next.addr = {mem_addr_i[15:1], 1'b0};
            // Unwritten lane keeps erased value; AND keeps zeros
            if (program_width_select_i && cur_reg.hold_vld) begin
              cur_next.ben = 2'b11;
              cur_next.data = {mem_wdata_i, cur_reg.hold_byte} &
                              flash_word_i;
              cur_next.hold_vld = 1'b0;
            end else if (mem_addr_i[0]) begin
              cur_next.ben = 2'b10;
              cur_next.data = {mem_wdata_i & flash_word_i[15:8],
                               fpec_pkg::ERASED_BYTE};
            end else begin
              cur_next.ben = 2'b01;
              cur_next.data = {fpec_pkg::ERASED_BYTE,
                               mem_wdata_i & flash_word_i[7:0]};
            end
          end
        end
      end
      fpec_pkg::FPEC_BP_SEL: begin
        if (cmd_wr_i) begin
          cur_next.st = fpec_pkg::FPEC_LOCKED;
        end
      end
      fpec_pkg::FPEC_PROG: begin
        if (op_done) begin
          cur_next.st = fpec_pkg::FPEC_UNLOCKED;
        end
      end
      fpec_pkg::FPEC_PERASE: begin
        if (op_done) begin
          cur_next.st = fpec_pkg::FPEC_LOCKED;
        end
      end
      fpec_pkg::FPEC_MERASE: begin
        if (op_done) begin
          cur_next.st = fpec_pkg::FPEC_LOCKED;
        end
      end
    endcase
    // Visible status and stall follow the next state
    cur_next.status = fpec_pkg::status_code(cur_next.st);
    cur_next.stall = cur_next.st == fpec_pkg::FPEC_PROG ||
                     cur_next.st == fpec_pkg::FPEC_PERASE ||
                     cur_next.st == fpec_pkg::FPEC_MERASE;
    // Read view lags a block protect write by one cycle
    cur_next.ps_rd = (cur_next.st == fpec_pkg::FPEC_BP_SEL) ?
                     bp_val : cur_next.page;
  end

  // State register; reset always lands in locked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_reg <= '0;
      cur_reg.st <= fpec_pkg::FPEC_LOCKED;
      cur_reg.page <= fpec_pkg::PAGE_SEL_RESET;
      cur_reg.ps_rd <= fpec_pkg::PAGE_SEL_RESET;
      cur_reg.status <= fpec_pkg::ST_LOCKED;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign controller_state_field_o = cur_reg.status;
  assign page_select_rdata_o = cur_reg.ps_rd;
  assign core_stall_o = cur_reg.stall;
  assign fl_prog_o = cur_reg.prog;
  assign fl_page_erase_o = cur_reg.perase;
  assign fl_mass_erase_o = cur_reg.merase;
  assign fl_info_o = cur_reg.info;
  assign fl_addr_o = cur_reg.addr;
  assign fl_data_o = cur_reg.data;
  assign fl_byte_en_o = cur_reg.ben;
  assign refused_o = cur_reg.refused;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  chk_wp_blocks_prog: assert property (
    !write_protect_option_i && mem_wr_i && !cmd_wr_i |=> !fl_prog_o)
    else $error("program started with write protect cleared");

  chk_byte_prog: assert property (
    cur_reg.st == fpec_pkg::FPEC_UNLOCKED && mem_wr_i && !cmd_wr_i &&
    user_ok && page_hit && !program_width_select_i |=>
    fl_prog_o && core_stall_o &&
    fl_byte_en_o == {$past(mem_addr_i[0]), !$past(mem_addr_i[0])})
    else $error("byte write did not program its lane");

  chk_even_held: assert property (
    cur_reg.st == fpec_pkg::FPEC_UNLOCKED && mem_wr_i && !cmd_wr_i &&
    user_ok && page_hit && program_width_select_i && !mem_addr_i[0] |=>
    !fl_prog_o && !core_stall_o)
    else $error("even byte started a program");

  chk_unlock_match: assert property (
    cur_reg.st == fpec_pkg::FPEC_KEY2 && ps_wr_i &&
    wr_data_i == cur_reg.page |=>
    controller_state_field_o == fpec_pkg::ST_UNLOCKED)
    else $error("matching page write did not unlock");

  chk_unlock_mismatch: assert property (
    cur_reg.st == fpec_pkg::FPEC_KEY2 && ps_wr_i &&
    wr_data_i != cur_reg.page |=>
    controller_state_field_o == fpec_pkg::ST_LOCKED)
    else $error("mismatching page write did not relock");

  chk_bad_cmd_lock: assert property (
    cur_reg.st == fpec_pkg::FPEC_UNLOCKED && cmd_wr_i &&
    wr_data_i != fpec_pkg::CMD_PAGE_ERASE &&
    wr_data_i != fpec_pkg::CMD_MASS_ERASE |=>
    controller_state_field_o == fpec_pkg::ST_LOCKED)
    else $error("other command left page open");

  chk_bp_select: assert property (
    cur_reg.st == fpec_pkg::FPEC_LOCKED && cmd_wr_i &&
    wr_data_i == fpec_pkg::CMD_BP_SELECT |=>
    controller_state_field_o == fpec_pkg::ST_BP_SEL)
    else $error("block protect select not entered");

  chk_bp_sticky: assert property (
    bp_val[fpec_pkg::BP_EN_BIT] |=> $stable(bp_val))
    else $error("enabled block protect changed");

  chk_prot_erase: assert property (
    cur_reg.st == fpec_pkg::FPEC_UNLOCKED && cmd_wr_i && page_prot &&
    !(dbg_i && wr_data_i == fpec_pkg::CMD_MASS_ERASE) |=>
    !fl_page_erase_o ##0 controller_state_field_o == fpec_pkg::ST_LOCKED)
    else $error("protected page erase not refused");

  chk_perase_relock: assert property (
    cur_reg.st == fpec_pkg::FPEC_PERASE && op_done |=>
    controller_state_field_o == fpec_pkg::ST_LOCKED && !core_stall_o)
    else $error("page erase did not relock");

  chk_stall_busy: assert property (
    core_stall_o == (controller_state_field_o[2] &&
                     controller_state_field_o != fpec_pkg::ST_BP_SEL))
    else $error("stall does not match busy state");

  chk_prog_clears: assert property (
    fl_prog_o |->
    (fl_data_o & ~$past(flash_word_i) &
     {{8{fl_byte_en_o[1]}}, {8{fl_byte_en_o[0]}}}) == 16'h0000 &&
    (fl_byte_en_o[1] || fl_data_o[15:8] == fpec_pkg::ERASED_BYTE) &&
    (fl_byte_en_o[0] || fl_data_o[7:0] == fpec_pkg::ERASED_BYTE) &&
    (!fl_byte_en_o[1] ||
     fl_data_o[15:8] == ($past(mem_wdata_i) & $past(flash_word_i[15:8]))))
    else $error("program would set a bit");

  chk_mass_no_info: assert property (
    fl_mass_erase_o |-> !fl_info_o ##1 core_stall_o)
    else $error("mass erase touched info area");

  cov_unlock: cover property (
    cur_reg.st == fpec_pkg::FPEC_KEY2 ##1
    cur_reg.st == fpec_pkg::FPEC_UNLOCKED);
  cov_word_prog: cover property (fl_prog_o && fl_byte_en_o == 2'b11);
  cov_page_erase: cover property (fl_page_erase_o);
  cov_mass_erase: cover property (fl_mass_erase_o);
endmodule // fpec_flash_ctrl

// file: fpec_pkg.sv
// Shared constants, types and decode helpers for the flash sequencer
package fpec_pkg;

  // Command byte values
  localparam logic [7:0] CMD_KEY1 = 8'h73;
  localparam logic [7:0] CMD_KEY2 = 8'h8C;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
  localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
  localparam logic [7:0] CMD_BP_SELECT = 8'h5E;

  // Status field codes
  localparam logic [2:0] ST_LOCKED = 3'h0;
  localparam logic [2:0] ST_KEY1 = 3'h1;
  localparam logic [2:0] ST_KEY2 = 3'h2;
  localparam logic [2:0] ST_UNLOCKED = 3'h3;
  localparam logic [2:0] ST_BP_SEL = 3'h4;
  localparam logic [2:0] ST_PROG = 3'h5;
  localparam logic [2:0] ST_PERASE = 3'h6;
  localparam logic [2:0] ST_MERASE = 3'h7;

  // Field layout of page select and block protect
  localparam int PAGE_W = 7;
  localparam int INFO_BIT = 7;
  localparam int BP_EN_BIT = 7;
  localparam int ADDR_PAGE_LSB = 9;
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] BLOCK_PROT_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Operation times and derived cycle counts at 40 MHz
  localparam int CLK_PERIOD_NS = 25;
  localparam int PROG_TIME_NS = 40000;
  localparam int PAGE_ERASE_TIME_NS = 10000000;
  localparam int MASS_ERASE_TIME_NS = 20000000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PAGE_ERASE_CYC =
    (PAGE_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MASS_ERASE_CYC =
    (MASS_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 20;

  typedef enum logic [2:0] {
    FPEC_LOCKED, FPEC_KEY1, FPEC_KEY2, FPEC_UNLOCKED,
    FPEC_BP_SEL, FPEC_PROG, FPEC_PERASE, FPEC_MERASE
  } fpec_state_t;

  // Page lies below the first unprotected page while protection is on
  function automatic logic page_protected(input logic [7:0] page,
                                          input logic [7:0] bp);
    return bp[BP_EN_BIT] && (page[PAGE_W-1:0] < bp[PAGE_W-1:0]);
  endfunction

  // Visible status code of a state
  function automatic logic [2:0] status_code(input fpec_state_t st);
    unique case (st)
      FPEC_LOCKED: return ST_LOCKED;
      FPEC_KEY1: return ST_KEY1;
      FPEC_KEY2: return ST_KEY2;
      FPEC_UNLOCKED: return ST_UNLOCKED;
      FPEC_BP_SEL: return ST_BP_SEL;
      FPEC_PROG: return ST_PROG;
      FPEC_PERASE: return ST_PERASE;
      FPEC_MERASE: return ST_MERASE;
    endcase
  endfunction

endpackage

// file: fpec_op_timer.sv
// Down counter timing one program or erase operation
`timescale 1ns/1ps
module fpec_op_timer #(
  parameter int W = 20
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [W-1:0] cycles_i,
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } fpec_tmr_t;

  fpec_tmr_t cur_reg;
  fpec_tmr_t cur_next;

  // Done pulses on the last counted cycle
  always_comb begin
    cur_next = cur_reg;
    cur_next.done = 1'b0;
    if (load_i) begin
      cur_next.cnt = cycles_i;
    end else if (cur_reg.cnt != '0) begin
      cur_next.cnt = cur_reg.cnt - 1'b1;
      cur_next.done = (cur_reg.cnt == W'(1));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign done_o = cur_reg.done;
endmodule // fpec_op_timer

// file: fpec_block_prot.sv
// Block protect register, frozen once protection is enabled
`timescale 1ns/1ps
module fpec_block_prot (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] bp_o
);
  typedef struct packed {
    logic [7:0] bp;
  } fpec_bp_t;

  fpec_bp_t cur_reg;
  fpec_bp_t cur_next;

  // Only system reset releases an enabled block
  always_comb begin
    cur_next = cur_reg;
    if (wr_i && !cur_reg.bp[fpec_pkg::BP_EN_BIT]) begin
      cur_next.bp = data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur_reg.bp <= fpec_pkg::BLOCK_PROT_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign bp_o = cur_reg.bp;
endmodule // fpec_block_prot

// file: fpec_flash_model.sv
// Behavioural flash array behind the sequencer's program and erase strobes
`timescale 1ns/1ps
module fpec_flash_model (
  input wire logic clk_i,
  input wire logic prog_i,
  input wire logic page_erase_i,
  input wire logic mass_erase_i,
  input wire logic info_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] data_i,
  input wire logic [1:0] byte_en_i,
  input wire logic [15:0] rd_addr_i,
  output logic [15:0] rd_word_o
);
  logic [7:0] main_mem [0:65535];
  logic [7:0] info_mem [0:1023];
  // Array starts cleared so every erase is visible
  initial begin
    for (int i = 0; i < 65536; i++) main_mem[i] = 8'h00;
    for (int i = 0; i < 1024; i++) info_mem[i] = 8'h00;
  end
  // Read port answers in the same cycle as the address
  assign rd_word_o = {main_mem[{rd_addr_i[15:1], 1'b1}],
                      main_mem[{rd_addr_i[15:1], 1'b0}]};
  // Programming only pulls bits low; erase restores ones
  always @(posedge clk_i) begin
    if (prog_i && byte_en_i[0])
      main_mem[{addr_i[15:1], 1'b0}] &= data_i[7:0];
    if (prog_i && byte_en_i[1])
      main_mem[{addr_i[15:1], 1'b1}] &= data_i[15:8];
    if (page_erase_i && info_i)
      for (int i = 0; i < 512; i++) info_mem[i] = 8'hFF;
    if (page_erase_i && !info_i)
      for (int i = 0; i < 512; i++)
        main_mem[{addr_i[15:9], 9'h000} + i] = 8'hFF;
    // Info area left alone by a mass erase
    if (mass_erase_i)
      for (int i = 0; i < 65536; i++) main_mem[i] = 8'hFF;
  end
endmodule // fpec_flash_model

// file: tb_fpec_flash_ctrl.sv
// Self-checking bench for the flash program and erase sequencer
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected at %0t ns: %s", $time, m); end end
module tb_fpec_flash_ctrl;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_wr = 1'b0;
  logic ps_wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic dbg = 1'b0;
  logic wp = 1'b1;
  logic width = 1'b0;
  logic mem_wr = 1'b0;
  logic [15:0] maddr = 16'h0000;
  logic [7:0] mdata = 8'h00;
  logic [15:0] fword;
  logic [2:0] st;
  logic [7:0] rdata;
  logic stall, prog, perase, merase, info, refused;
  logic [15:0] faddr, fdata;
  logic [1:0] be, last_be;
  logic seen_info = 1'b1;
  int n_mismatch = 0;
  int n_tests = 0;
  int n_prog = 0;
  int n_ref = 0;
  int k;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  fpec_flash_ctrl #(.PAGE_ERASE_CYCLES(20), .MASS_ERASE_CYCLES(20)) uut (
    .clk_i(clk), .rst_n_i(rst_n), .cmd_wr_i(cmd_wr), .ps_wr_i(ps_wr),
    .wr_data_i(wdata), .dbg_i(dbg), .write_protect_option_i(wp),
    .program_width_select_i(width), .mem_wr_i(mem_wr),
    .mem_addr_i(maddr), .mem_wdata_i(mdata), .flash_word_i(fword),
    .controller_state_field_o(st), .page_select_rdata_o(rdata),
    .core_stall_o(stall), .fl_prog_o(prog), .fl_page_erase_o(perase),
    .fl_mass_erase_o(merase), .fl_info_o(info), .fl_addr_o(faddr),
    .fl_data_o(fdata), .fl_byte_en_o(be), .refused_o(refused));

  fpec_flash_model fm (
    .clk_i(clk), .prog_i(prog), .page_erase_i(perase),
    .mass_erase_i(merase), .info_i(info), .addr_i(faddr), .data_i(fdata),
    .byte_en_i(be), .rd_addr_i(maddr), .rd_word_o(fword));

  // One-cycle pulses are counted on the edge where they stand
  always @(posedge clk) begin
    if (prog === 1'b1) begin
      n_prog++;
      last_be = be;
    end
    if (refused === 1'b1) n_ref++;
    if (merase === 1'b1) seen_info = info;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Register write: strobe high for one edge, driven at falling edge
  // Idle cycle after, so one-cycle pulses are counted before checks
  task automatic reg_wr(input logic is_cmd, input logic [7:0] d);
    @(negedge clk);
    wdata = d;
    cmd_wr = is_cmd;
    ps_wr = !is_cmd;
    @(negedge clk);
    cmd_wr = 1'b0;
    ps_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic mem_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    maddr = a;
    mdata = d;
    mem_wr = 1'b1;
    @(negedge clk);
    mem_wr = 1'b0;
    @(negedge clk);
  endtask

  // Bounded wait for a status code
  task automatic wait_st(input logic [2:0] code, input int bound);
    k = 0;
    while (st !== code && k < bound) begin
      @(negedge clk);
      k++;
    end
    `CHK(st, code, "status wait ran out")
    if (st !== code) print_verdict();
  endtask

  task automatic unlock(input logic [7:0] p1, input logic [7:0] p2,
                        input logic [2:0] fin);
    reg_wr(1'b0, p1);
    reg_wr(1'b1, fpec_pkg::CMD_KEY1);
    `CHK(st, fpec_pkg::ST_KEY1, "first key status")
    reg_wr(1'b1, fpec_pkg::CMD_KEY2);
    `CHK(st, fpec_pkg::ST_KEY2, "second key status")
    reg_wr(1'b0, p2);
    `CHK(st, fin, "status after page rewrite")
    `CHK(rdata, p2, "page select readback")
  endtask

  task automatic bp_read(input logic [7:0] e);
    repeat (2) @(negedge clk);
    `CHK(rdata, e, "block protect readback")
  endtask

  // Program one byte and wait for the operation to finish
  task automatic prog_byte(input logic [15:0] a, input logic [7:0] d);
    mem_write(a, d);
    `CHK(st, fpec_pkg::ST_PROG, "program status")
    `CHK(stall, 1'b1, "core not stalled")
    wait_st(fpec_pkg::ST_UNLOCKED, 3000);
    `CHK(stall, 1'b0, "stall after program")
  endtask

  // Hang guard, well above the longest clean run
  initial begin
    #1000000;
    n_mismatch++;
    $display("unexpected at %0t ns: run limit reached", $time);
    print_verdict();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK(st, fpec_pkg::ST_LOCKED, "status after reset")
    // Block protect: select, enable pages 0..3, then try to clear
    reg_wr(1'b1, fpec_pkg::CMD_BP_SELECT);
    `CHK(st, fpec_pkg::ST_BP_SEL, "redirect status")
    bp_read(8'h00);
    reg_wr(1'b0, 8'h84);
    bp_read(8'h84);
    reg_wr(1'b1, 8'h00);
    `CHK(st, fpec_pkg::ST_LOCKED, "redirect cancel")
    reg_wr(1'b1, fpec_pkg::CMD_BP_SELECT);
    reg_wr(1'b0, 8'h00);
    bp_read(8'h84);
    reg_wr(1'b1, 8'h00);
    $display("test block protect done");
    // Last protected page refuses program and erase
    unlock(8'h03, 8'h03, fpec_pkg::ST_UNLOCKED);
    k = n_ref;
    mem_write(16'h0600, 8'h00);
    `CHK(n_ref, k + 1, "protected program not refused")
    reg_wr(1'b1, fpec_pkg::CMD_PAGE_ERASE);
    `CHK(st, fpec_pkg::ST_LOCKED, "protected erase status")
    `CHK(n_ref, k + 2, "protected erase not refused")
    // First unprotected page erases, then relocks
    unlock(8'h04, 8'h04, fpec_pkg::ST_UNLOCKED);
    reg_wr(1'b1, fpec_pkg::CMD_PAGE_ERASE);
    `CHK(st, fpec_pkg::ST_PERASE, "erase status")
    `CHK(stall, 1'b1, "erase stall")
    wait_st(fpec_pkg::ST_LOCKED, 100);
    `CHK(fm.main_mem[16'h0800], 8'hFF, "page start")
    `CHK(fm.main_mem[16'h09FF], 8'hFF, "page end")
    `CHK(fm.main_mem[16'h0A00], 8'h00, "next page hit")
    $display("test page erase done");
    // Byte mode programs, only clearing bits, twice to the same byte
    unlock(8'h04, 8'h04, fpec_pkg::ST_UNLOCKED);
    prog_byte(16'h0805, 8'hA5);
    `CHK(fm.main_mem[16'h0805], 8'hA5, "byte program")
    `CHK(last_be, 2'b10, "byte lane")
    prog_byte(16'h0805, 8'h5A);
    `CHK(fm.main_mem[16'h0805], 8'h00, "second program")
    k = n_ref;
    mem_write(16'h0A00, 8'h12);
    `CHK(n_ref, k + 1, "other page not refused")
    `CHK(st, fpec_pkg::ST_UNLOCKED, "page closed")
    // Word mode: held even byte, replaced even byte, lone odd byte
    width = 1'b1;
    k = n_prog;
    mem_write(16'h0810, 8'h11);
    @(negedge clk);
    `CHK(n_prog, k, "even byte programmed alone")
    prog_byte(16'h0811, 8'h22);
    `CHK(fm.main_mem[16'h0810], 8'h11, "word low")
    `CHK(fm.main_mem[16'h0811], 8'h22, "word high")
    `CHK(last_be, 2'b11, "word lanes")
    prog_byte(16'h0821, 8'h33);
    `CHK(fm.main_mem[16'h0820], 8'hFF, "lone odd even byte")
    `CHK(fm.main_mem[16'h0821], 8'h33, "lone odd byte")
    mem_write(16'h0830, 8'h44);
    mem_write(16'h0832, 8'h55);
    prog_byte(16'h0833, 8'h66);
    `CHK(fm.main_mem[16'h0830], 8'hFF, "replaced even")
    `CHK(fm.main_mem[16'h0832], 8'h55, "held even")
    width = 1'b0;
    reg_wr(1'b1, 8'h00);
    `CHK(st, fpec_pkg::ST_LOCKED, "relock by command")
    k = n_prog;
    mem_write(16'h0840, 8'h00);
    `CHK(n_prog, k, "program while locked")
    $display("test program done");
    // Page mismatch and out-of-order keys
    unlock(8'h05, 8'h06, fpec_pkg::ST_LOCKED);
    reg_wr(1'b1, fpec_pkg::CMD_KEY2);
    `CHK(st, fpec_pkg::ST_LOCKED, "key2 first")
    reg_wr(1'b1, fpec_pkg::CMD_KEY1);
    reg_wr(1'b0, 8'h05);
    `CHK(st, fpec_pkg::ST_LOCKED, "page after key1")
    // Write-protect option cleared
    wp = 1'b0;
    unlock(8'h04, 8'h04, fpec_pkg::ST_UNLOCKED);
    mem_write(16'h0850, 8'h12);
    `CHK(fm.main_mem[16'h0850], 8'hFF, "program with protect")
    reg_wr(1'b1, fpec_pkg::CMD_PAGE_ERASE);
    `CHK(st, fpec_pkg::ST_LOCKED, "erase with protect")
    `CHK(fm.main_mem[16'h0805], 8'h00, "page erased anyway")
    // User mass erase refused; debugger mass erase allowed
    wp = 1'b1;
    unlock(8'h05, 8'h05, fpec_pkg::ST_UNLOCKED);
    reg_wr(1'b1, fpec_pkg::CMD_MASS_ERASE);
    `CHK(st, fpec_pkg::ST_LOCKED, "user mass erase")
    wp = 1'b0;
    dbg = 1'b1;
    unlock(8'h05, 8'h05, fpec_pkg::ST_UNLOCKED);
    reg_wr(1'b1, fpec_pkg::CMD_MASS_ERASE);
    `CHK(st, fpec_pkg::ST_MERASE, "mass erase status")
    wait_st(fpec_pkg::ST_LOCKED, 100);
    `CHK(fm.main_mem[16'h0000], 8'hFF, "mass erase low")
    `CHK(fm.main_mem[16'h0805], 8'hFF, "mass erase mid")
    `CHK(seen_info, 1'b0, "mass erase info flag")
    `CHK(fm.info_mem[0], 8'h00, "info page touched")
    dbg = 1'b0;
    wp = 1'b1;
    // Only a page erase clears the info user page
    unlock(8'h84, 8'h84, fpec_pkg::ST_UNLOCKED);
    reg_wr(1'b1, fpec_pkg::CMD_PAGE_ERASE);
    `CHK(st, fpec_pkg::ST_PERASE, "info erase status")
    wait_st(fpec_pkg::ST_LOCKED, 100);
    `CHK(fm.info_mem[0], 8'hFF, "info page not erased")
    $display("test protect and mass erase done");
    // Reset in mid-run relocks and clears block protect
    unlock(8'h06, 8'h06, fpec_pkg::ST_UNLOCKED);
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    `CHK(st, fpec_pkg::ST_LOCKED, "status after second reset")
    reg_wr(1'b1, fpec_pkg::CMD_BP_SELECT);
    bp_read(8'h00);
    $display("test second reset done");
    print_verdict();
  end
endmodule // tb_fpec_flash_ctrl
